// ==== logic/ise_pkg.sv ====
// ise_pkg: constants and types shared by the serial memory slave files
// assumes a single 125 MHz core clock samples the two-wire bus pins
package ise_pkg;

   localparam int          CLK_FREQ_MHZ              = 125;
   localparam int          INTERNAL_PROGRAM_TIME_US  = 5000;
   localparam int          INTERNAL_PROGRAM_CYCLES   = INTERNAL_PROGRAM_TIME_US * CLK_FREQ_MHZ;
   localparam int          PROG_TIMER_W              = 20;

   localparam int          ADDR_W                    = 13;
   localparam int          MEM_DEPTH                 = 8192;
   localparam int          PAGE_BYTES                = 32;
   localparam int          PAGE_OFS_W                = 5;
   localparam int          BITS_PER_BYTE             = 8;
   localparam logic [7:0]  ERASED_BYTE               = 8'hFF;

   // select byte fields
   localparam int          SEL_TYPE_MSB              = 7;
   localparam int          SEL_TYPE_LSB              = 4;
   localparam int          SEL_PIN_MSB               = 3;
   localparam int          SEL_PIN_LSB               = 1;
   localparam int          SEL_DIR_BIT               = 0;
   localparam int          ADDR_HI_BITS              = 5;

   // synchroniser lanes: scl, sda, wp, select pins 0..2
   localparam int          SYNC_W                    = 6;
   localparam int          LANE_SCL                  = 0;
   localparam int          LANE_SDA                  = 1;
   localparam int          LANE_WP                   = 2;
   localparam int          LANE_SEL0                 = 3;
   localparam logic [5:0]  SYNC_RESET                = 6'h03;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_RX     = 3'h1,
      ST_ACK    = 3'h2,
      ST_TX     = 3'h3,
      ST_TXACK  = 3'h4,
      ST_TXLOAD = 3'h5,
      ST_WAIT   = 3'h6
   } ise_state_t;

   typedef enum logic [1:0] {
      PH_SEL  = 2'h0,
      PH_AHI  = 2'h1,
      PH_ALO  = 2'h2,
      PH_DATA = 2'h3
   } ise_phase_t;

endpackage

// ==== logic/ise_bus_if.sv ====
// ise_bus_if: conditioned bus events from the line conditioner to the core
// all signals are on the core clock; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface ise_bus_if;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       sda_bit;
   logic       wp_level;
   logic [2:0] sel_pins;

   modport cond (output scl_rise, scl_fall, start_det, stop_det, sda_bit, wp_level, sel_pins);
   modport core (input  scl_rise, scl_fall, start_det, stop_det, sda_bit, wp_level, sel_pins);
endinterface
`default_nettype wire

// ==== logic/ise_line_cond.sv ====
// ise_line_cond: synchronises bus pins and straps, finds clock edges and frame delimiters
// assumes pins are asynchronous to clk and the bus clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none
module ise_line_cond
   import ise_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic wp,
   input  wire logic select_pin_bit0,
   input  wire logic select_pin_bit1,
   input  wire logic select_pin_bit2,
   ise_bus_if.cond   bus
);

   logic [SYNC_W-1:0] meta;
   logic [SYNC_W-1:0] sync;
   logic              prev_scl;
   logic              prev_sda;
   logic [SYNC_W-1:0] next_meta;
   logic [SYNC_W-1:0] next_sync;
   logic              next_prev_scl;
   logic              next_prev_sda;

   always_comb begin
      next_meta     = meta;
      next_sync     = sync;
      next_prev_scl = prev_scl;
      next_prev_sda = prev_sda;
      if (ce) begin
         next_meta     = {select_pin_bit2, select_pin_bit1, select_pin_bit0, wp, sda, scl};
         next_sync     = meta;
         next_prev_scl = sync[LANE_SCL];
         next_prev_sda = sync[LANE_SDA];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta     <= SYNC_RESET;
         sync     <= SYNC_RESET;
         prev_scl <= 1'h1;
         prev_sda <= 1'h1;
      end else begin
         meta     <= next_meta;
         sync     <= next_sync;
         prev_scl <= next_prev_scl;
         prev_sda <= next_prev_sda;
      end
   end

   // edges come only from the second stage, never from meta
   assign bus.scl_rise  = ce &&  sync[LANE_SCL] && !prev_scl;
   assign bus.scl_fall  = ce && !sync[LANE_SCL] &&  prev_scl;
   // sda edge while scl high both before and now marks a frame edge
   assign bus.start_det = ce && sync[LANE_SCL] && prev_scl && !sync[LANE_SDA] && prev_sda; // see R5
   assign bus.stop_det  = ce && sync[LANE_SCL] && prev_scl &&  sync[LANE_SDA] && !prev_sda; // see R5
   assign bus.sda_bit   = sync[LANE_SDA];
   assign bus.wp_level  = sync[LANE_WP];
   assign bus.sel_pins  = sync[LANE_SEL0+2:LANE_SEL0];

endmodule
`default_nettype wire

// ==== logic/ise_eeprom.sv ====
// ise_eeprom: two-wire serial memory slave with 8 KiB array, page buffer and write timer
// assumes the bus master drives scl; sda is open drain resolved outside from sda_oe
// Function
// R1: leave reset into standby when power good
// R2: power loss returns logic to reset state
// R3: sample on scl rise, change after fall
// R4: only pull sda low or release
// R5: start and stop are sda edges, scl high
// R6: ignore until start; stop ends command
// R7: master keeps sda stable while scl high
// R8: ack only matching type and pin bits
// R9: select lsb one reads, zero writes
// R10: ninth clock carries ack or nack
// R11: byte write: select, two addresses, data
// R12: stop launches program; busy nacks select
// R13: page buffer takes up to 32 bytes
// R14: page fixed, offset wraps within page
// R15: whole buffered page programmed in one cycle
// R16: master polls select until acknowledged
// R17: sample wp at fall before first data
// R18: wp high nacks data, discards write
// R19: array starts as all ones
// R20: read select returns current address byte
// R21: master nack then stop ends read
// R22: random read: address, repeated start, read
// R23: keep sending while master acknowledges
// R24: read address wraps over whole array
// R25: 8192 bytes, 13 address bits used
// R26: pointer sits one past last access
`timescale 1ns/1ps
`default_nettype none
module ise_eeprom
   import ise_pkg::*;
#(
   parameter int         PROGRAM_CYCLES   = INTERNAL_PROGRAM_CYCLES,
   parameter logic [3:0] DEVICE_TYPE_CODE = 4'h6 // arbitrary value
)(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   input  wire logic scl,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   input  wire logic wp,
   input  wire logic select_pin_bit0,
   input  wire logic select_pin_bit1,
   input  wire logic select_pin_bit2,
   output logic      write_busy
);

   ise_bus_if bus ();

   ise_line_cond u_cond (
      .clk             (clk),
      .rst_b           (rst_b),
      .ce              (ce),
      .scl             (scl),
      .sda             (sda_in),
      .wp              (wp),
      .select_pin_bit0 (select_pin_bit0),
      .select_pin_bit1 (select_pin_bit1),
      .select_pin_bit2 (select_pin_bit2),
      .bus             (bus)
   );

   logic [7:0]              mem [MEM_DEPTH];
   logic [7:0]              pbuf [PAGE_BYTES];

   ise_state_t              state,      next_state;
   ise_phase_t              phase,      next_phase;
   logic [3:0]              cnt,        next_cnt;
   logic [7:0]              shreg,      next_shreg;
   logic [7:0]              txreg,      next_txreg;
   logic                    oe,         next_oe;
   logic                    rd_dir,     next_rd_dir;
   logic [ADDR_W-1:0]       addr_ptr,   next_addr_ptr;
   logic                    wp_latched, next_wp_latched;
   logic [PAGE_BYTES-1:0]   valid,      next_valid;
   logic                    prog_busy,  next_prog_busy;
   logic [PROG_TIMER_W-1:0] prog_timer, next_prog_timer;
   logic [PAGE_OFS_W:0]     prog_idx,   next_prog_idx;
   logic                    buf_we;
   logic [PAGE_OFS_W-1:0]   buf_idx;
   logic                    mem_we;
   logic [ADDR_W-1:0]       mem_waddr;
   logic [7:0]              rd_byte;
   logic                    sel_match;
   logic                    launch;

   // delivered erased
   initial begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
         mem[i] = ERASED_BYTE; // see R19
      end
   end

   assign rd_byte   = mem[addr_ptr]; // see R25
   assign sel_match = shreg[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEVICE_TYPE_CODE
                   && shreg[SEL_PIN_MSB:SEL_PIN_LSB] == bus.sel_pins; // see R8
   assign launch    = bus.stop_det && phase == PH_DATA && (|valid) && !prog_busy;

   always_comb begin
      next_state      = state;
      next_phase      = phase;
      next_cnt        = cnt;
      next_shreg      = shreg;
      next_txreg      = txreg;
      next_oe         = oe;
      next_rd_dir     = rd_dir;
      next_addr_ptr   = addr_ptr;
      next_wp_latched = wp_latched;
      next_valid      = valid;
      buf_we          = 1'h0;
      buf_idx         = addr_ptr[PAGE_OFS_W-1:0];
      if (ce) begin
         if (bus.start_det) begin
            // repeated start keeps the pointer for random reads
            next_state = ST_RX; // see R6, R22
            next_phase = PH_SEL;
            next_cnt   = 4'h0;
            next_oe    = 1'h0;
         end else if (bus.stop_det) begin
            next_state = ST_IDLE; // see R6, R21
            next_phase = PH_SEL;
            next_oe    = 1'h0;
         end else begin
            unique case (state)
               ST_IDLE, ST_WAIT: begin
               end
               ST_RX: begin
                  if (bus.scl_rise && cnt < 4'(BITS_PER_BYTE)) begin
                     next_shreg = {shreg[6:0], bus.sda_bit}; // see R3
                     next_cnt   = cnt + 4'h1;
                  end else if (bus.scl_fall && cnt == 4'(BITS_PER_BYTE)) begin
                     next_oe    = 1'h1; // see R10
                     next_state = ST_ACK;
                     unique case (phase)
                        PH_SEL: begin
                           // busy array or foreign select: leave sda released
                           if (!sel_match || prog_busy) begin // see R8, R12, R16
                              next_oe    = 1'h0;
                              next_state = ST_WAIT;
                           end
                           next_rd_dir = shreg[SEL_DIR_BIT]; // see R9
                        end
                        PH_AHI: begin
                           next_addr_ptr[ADDR_W-1:BITS_PER_BYTE] = shreg[ADDR_HI_BITS-1:0]; // see R25
                        end
                        PH_ALO: begin
                           next_addr_ptr[BITS_PER_BYTE-1:0] = shreg; // see R11
                           next_valid = '0;
                        end
                        PH_DATA: begin
                           if (wp_latched) begin
                              next_oe    = 1'h0; // see R18
                              next_state = ST_WAIT;
                              next_valid = '0;
                           end else begin
                              buf_we                   = 1'h1; // see R13
                              next_valid[buf_idx]      = 1'h1;
                              next_addr_ptr[PAGE_OFS_W-1:0] = buf_idx + 5'h01; // see R14, R26
                           end
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (bus.scl_fall) begin
                     next_oe  = 1'h0;
                     next_cnt = 4'h0;
                     next_state = ST_RX;
                     unique case (phase)
                        PH_SEL: begin
                           if (rd_dir) begin
                              next_state    = ST_TX; // see R20
                              next_oe       = !rd_byte[7]; // see R4
                              next_txreg    = {rd_byte[6:0], 1'h0};
                              next_cnt      = 4'h1;
                              next_addr_ptr = addr_ptr + 13'h0001; // see R24, R26
                           end else begin
                              next_phase = PH_AHI;
                           end
                        end
                        PH_AHI: next_phase = PH_ALO;
                        PH_ALO: begin
                           next_phase      = PH_DATA;
                           next_wp_latched = bus.wp_level; // see R17
                        end
                        PH_DATA: next_phase = PH_DATA;
                     endcase
                  end
               end
               ST_TX: begin
                  if (bus.scl_fall) begin
                     if (cnt < 4'(BITS_PER_BYTE)) begin
                        next_oe    = !txreg[7]; // see R3, R4
                        next_txreg = {txreg[6:0], 1'h0};
                        next_cnt   = cnt + 4'h1;
                     end else begin
                        next_oe    = 1'h0; // see R10
                        next_state = ST_TXACK;
                     end
                  end
               end
               ST_TXACK: begin
                  if (bus.scl_rise) begin
                     next_state = bus.sda_bit ? ST_WAIT : ST_TXLOAD; // see R21, R23
                  end
               end
               ST_TXLOAD: begin
                  if (bus.scl_fall) begin
                     next_state    = ST_TX; // see R23
                     next_oe       = !rd_byte[7];
                     next_txreg    = {rd_byte[6:0], 1'h0};
                     next_cnt      = 4'h1;
                     next_addr_ptr = addr_ptr + 13'h0001; // see R24
                  end
               end
               default: begin
                  next_state = ST_IDLE;
                  next_oe    = 1'h0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state      <= ST_IDLE; // see R1, R2
         phase      <= PH_SEL;
         cnt        <= 4'h0;
         shreg      <= 8'h00;
         txreg      <= 8'h00;
         oe         <= 1'h0;
         rd_dir     <= 1'h0;
         addr_ptr   <= '0;
         wp_latched <= 1'h0;
         valid      <= '0;
      end else begin
         state      <= next_state;
         phase      <= next_phase;
         cnt        <= next_cnt;
         shreg      <= next_shreg;
         txreg      <= next_txreg;
         oe         <= next_oe;
         rd_dir     <= next_rd_dir;
         addr_ptr   <= next_addr_ptr;
         wp_latched <= next_wp_latched;
         valid      <= next_valid;
      end
   end

   always_ff @(posedge clk) begin
      if (buf_we) begin
         pbuf[buf_idx] <= shreg; // see R14
      end
   end

   // program engine: copies one page slot per clock, then waits out the timer
   always_comb begin
      next_prog_busy  = prog_busy;
      next_prog_timer = prog_timer;
      next_prog_idx   = prog_idx;
      mem_we          = 1'h0;
      mem_waddr       = {addr_ptr[ADDR_W-1:PAGE_OFS_W], prog_idx[PAGE_OFS_W-1:0]};
      if (ce) begin
         if (launch) begin
            next_prog_busy  = 1'h1; // see R12
            next_prog_timer = '0;
            next_prog_idx   = '0;
         end else if (prog_busy) begin
            next_prog_timer = prog_timer + 20'h00001;
            if (prog_idx < 6'(PAGE_BYTES)) begin
               mem_we        = valid[prog_idx[PAGE_OFS_W-1:0]]; // see R15
               next_prog_idx = prog_idx + 6'h01;
            end else if (prog_timer >= PROG_TIMER_W'(PROGRAM_CYCLES - 1)) begin
               next_prog_busy = 1'h0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prog_busy  <= 1'h0; // see R2
         prog_timer <= '0;
         prog_idx   <= '0;
      end else begin
         prog_busy  <= next_prog_busy;
         prog_timer <= next_prog_timer;
         prog_idx   <= next_prog_idx;
      end
   end

   always @(posedge clk) begin // plain always: the erase loop also writes mem
      if (mem_we) begin
         mem[mem_waddr] <= pbuf[prog_idx[PAGE_OFS_W-1:0]];
      end
   end

   // sda data level is constant low; only the enable moves
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sda_out    <= 1'h0;
         sda_oe     <= 1'h0;
         write_busy <= 1'h0;
      end else begin
         sda_out    <= 1'h0; // see R4
         sda_oe     <= next_oe;
         write_busy <= next_prog_busy;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_por_standby: assert property (disable iff (1'h0) !rst_b |=> state == ST_IDLE && !prog_busy && !sda_oe) // see R1
      else $error("reset did not return to standby");
   a_never_high: assert property (sda_oe |-> sda_out == 1'h0) // see R4
      else $error("sda driven high");
   a_oe_on_fall: assert property ($changed(oe) |-> $past(ce && (bus.scl_fall || bus.start_det || bus.stop_det))) // see R3
      else $error("sda enable moved outside scl fall");
   a_idle_until_start: assert property (state == ST_IDLE && !(ce && bus.start_det) |=> state == ST_IDLE) // see R6
      else $error("left idle without start");
   a_stop_ends: assert property (ce && bus.stop_det |=> state == ST_IDLE && !oe) // see R6
      else $error("stop did not end command");
   a_sel_match: assert property ($rose(state == ST_ACK) && phase == PH_SEL |-> shreg[7:1] == {DEVICE_TYPE_CODE, bus.sel_pins}) // see R8
      else $error("acked foreign select");
   a_busy_nack: assert property (prog_busy && state == ST_ACK |-> phase != PH_SEL) // see R12
      else $error("acked select while programming");
   a_wp_nack: assert property (state == ST_ACK && phase == PH_DATA |-> !wp_latched) // see R18
      else $error("acked data under write protect");
   a_prog_launch: assert property (ce && launch |=> prog_busy && prog_idx == 6'h00 ##1 prog_busy[*7]) // see R15
      else $error("stop after data did not launch program");
   a_page_fixed: assert property (state == ST_RX && phase == PH_DATA |=> $stable(addr_ptr[12:5])) // see R14
      else $error("page address moved in page write");
   a_read_incr: assert property (ce && bus.scl_fall && state == ST_TXLOAD |=> addr_ptr == $past(addr_ptr) + 13'h0001) // see R24
      else $error("read pointer did not advance");

   c_write_launch: cover property (ce && launch ##1 prog_busy);
   c_read_byte: cover property (state == ST_TXACK ##[1:200] state == ST_TXLOAD);
   c_busy_poll: cover property (prog_busy && $rose(state == ST_WAIT));
   c_page_wrap: cover property (buf_we && buf_idx == 5'h1F);

endmodule
`default_nettype wire

// ==== tb/ise_master_model.sv ====
// ise_master_model: bus master driving scl and pulling sda, 160 ns bus clock
// assumes sda is resolved in the bench with a pull-up; tasks are called by tb
`timescale 1ns/1ps
`default_nettype none
module ise_master_model (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe
);
   initial begin
      scl    = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   // sda moves mid-low only, held through the high phase
   task automatic bit_io(input logic b, output logic r);
      wait_clk(5);
      sda_oe = ~b;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(5);
      r = sda;
      wait_clk(5);
      scl = 1'b0;
   endtask
   // also serves as repeated start
   task automatic start();
      wait_clk(5);
      sda_oe = 1'b0;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(10);
      sda_oe = 1'b1;
      wait_clk(10);
      scl = 1'b0;
   endtask
   task automatic stop();
      wait_clk(5);
      sda_oe = 1'b1;
      wait_clk(5);
      scl = 1'b1;
      wait_clk(10);
      sda_oe = 1'b0;
      wait_clk(20);
   endtask
   // msb first, sda released for the ninth clock
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // ack all but the last byte
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// tb: self-checking bench for the serial memory slave with a master model
// assumes ise_eeprom as top, pull-up on sda, program time cut to PROG cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ise_pkg::*;
   // long enough that the first poll still lands inside the program cycle
   localparam int         PROG = 1000;
   localparam logic [3:0] TYPE = 4'h6; // arbitrary value, same as the instance
   localparam logic [2:0] PINS = 3'h5;
   logic clk;
   logic rst_b;
   logic ce;
   logic scl;
   logic sda;
   logic m_oe;
   logic sda_out;
   logic sda_oe;
   logic wp;
   logic write_busy;
   int   n_errors;
   int   tests_run;
   assign sda = ~(m_oe | sda_oe);
   ise_eeprom #(.PROGRAM_CYCLES(PROG), .DEVICE_TYPE_CODE(TYPE)) dut_u (
      .clk(clk), .rst_b(rst_b), .ce(ce), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .select_pin_bit0(PINS[0]),
      .select_pin_bit1(PINS[1]), .select_pin_bit2(PINS[2]), .write_busy(write_busy));
   ise_master_model m_u (.clk(clk), .sda(sda), .scl(scl), .sda_oe(m_oe));
   initial clk = 1'b0;
   always #4 clk = ~clk;
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   always @(negedge clk) if (sda_oe === 1'b1) chk("drive level", 13'h0, {12'h000, sda_out});
   task automatic sel(input logic dir, output logic ack);
      m_u.start();
      m_u.wr_byte({TYPE, PINS, dir}, ack);
   endtask
   task automatic load_addr(input logic [12:0] a);
      logic ack;
      sel(1'b0, ack);
      chk("sel write ack", 13'h1, {12'h000, ack});
      m_u.wr_byte({3'h7, a[12:8]}, ack);
      chk("addr hi ack", 13'h1, {12'h000, ack});
      m_u.wr_byte(a[7:0], ack);
      chk("addr lo ack", 13'h1, {12'h000, ack});
   endtask
   // polls select until acked; expects a nack first while programming
   task automatic wait_ready(input logic busy_exp);
      logic ack;
      int   polls;
      polls = 0;
      ack = 1'b0;
      repeat (4) @(negedge clk);
      chk("busy after stop", {12'h000, busy_exp}, {12'h000, write_busy});
      while (ack !== 1'b1 && polls < 8) begin
         sel(1'b0, ack);
         m_u.stop();
         if (polls == 0) chk("first poll ack", {12'h000, ~busy_exp}, {12'h000, ack});
         polls++;
      end
      chk("ready ack", 13'h1, {12'h000, ack});
   endtask
   task automatic do_write(input logic [12:0] a, input logic [7:0] d[$], input logic dack);
      logic ack;
      load_addr(a);
      foreach (d[i]) begin
         m_u.wr_byte(d[i], ack);
         chk("data ack", {12'h000, dack}, {12'h000, ack});
      end
      m_u.stop();
      wait_ready(dack);
   endtask
   task automatic do_read(input logic rnd, input logic [12:0] a, input logic [7:0] e[$]);
      logic       ack;
      logic [7:0] d;
      if (rnd) load_addr(a);
      sel(1'b1, ack);
      chk("sel read ack", 13'h1, {12'h000, ack});
      foreach (e[i]) begin
         m_u.rd_byte(i == e.size() - 1, d);
         chk("read byte", {5'h00, e[i]}, {5'h00, d});
      end
      m_u.stop();
   endtask
   task automatic t_select();
      logic       ack;
      logic [7:0] bad [2];
      bad = '{{~TYPE, PINS, 1'b1}, {TYPE, ~PINS, 1'b1}};
      foreach (bad[i]) begin
         m_u.start();
         m_u.wr_byte(bad[i], ack);
         chk("foreign sel ack", 13'h0, {12'h000, ack});
         m_u.stop();
      end
   endtask
   // last location, then wrap of a sequential read to zero
   task automatic t_byte();
      do_write(13'h1FFF, '{8'h5A}, 1'b1);
      do_read(1'b1, 13'h1FFE, '{8'hFF, 8'h5A, 8'hFF});
      do_read(1'b0, 13'h0000, '{8'hFF});
   endtask
   // start two short of page end, so the last two wrap to page start
   task automatic t_page();
      do_write(13'h041E, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
      do_read(1'b0, 13'h0000, '{8'hFF});
      do_read(1'b1, 13'h041E, '{8'h11, 8'h22, 8'hFF});
      do_read(1'b1, 13'h0400, '{8'h33, 8'h44});
   endtask
   task automatic t_wp();
      wp = 1'b1;
      do_write(13'h0100, '{8'hA5}, 1'b0);
      wp = 1'b0;
      do_read(1'b1, 13'h0100, '{8'hFF});
   endtask
   // reset during programming must clear busy and leave the bus usable
   task automatic t_reset();
      logic ack;
      load_addr(13'h0200);
      m_u.wr_byte(8'h77, ack);
      m_u.stop();
      repeat (40) @(negedge clk);
      // clock enable low must freeze the program timer past its span
      ce = 1'b0;
      repeat (1200) @(negedge clk);
      chk("busy frozen by ce", 13'h1, {12'h000, write_busy});
      ce = 1'b1;
      rst_b = 1'b0;
      repeat (4) @(negedge clk);
      chk("busy in reset", 13'h0, {12'h000, write_busy});
      chk("oe in reset", 13'h0, {12'h000, sda_oe});
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      sel(1'b0, ack);
      chk("sel after reset", 13'h1, {12'h000, ack});
      m_u.stop();
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      n_errors = 0;
      tests_run = 0;
      rst_b = 1'b0;
      ce = 1'b1;
      wp = 1'b0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      t_select();
      t_byte();
      t_page();
      t_wp();
      t_reset();
      finish_test();
   end
   // run needs about 14000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      finish_test();
   end
endmodule
`default_nettype wire
